// [rtl/ntr_defines.svh]
`ifndef NTR_DEFINES_SVH
`define NTR_DEFINES_SVH

// full ten-bit instruction codes
`define NTR_OPC_CPY_BA 10'h01e
`define NTR_OPC_CPY_AB 10'h00e
`define NTR_OPC_CPY_YA 10'h01f
`define NTR_OPC_CPY_AY 10'h00c
`define NTR_OPC_PACK_E 10'h01a
`define NTR_OPC_UNPK_E 10'h02a
`define NTR_OPC_CPY_AD 10'h029
`define NTR_OPC_CPY_DA 10'h051
`define NTR_OPC_CPY_ZA 10'h053
`define NTR_OPC_CPY_XA 10'h052
`define NTR_OPC_CPY_SA 10'h050
`define NTR_OPC_INC_Y 10'h013
`define NTR_OPC_DEC_Y 10'h017
// codes that carry an immediate, with their masks
`define NTR_OPC_LXY 10'h300
`define NTR_MSK_LXY 10'h300
`define NTR_OPC_LZ 10'h048
`define NTR_MSK_LZ 10'h3fc
`define NTR_OPC_RLD 10'h2c0
`define NTR_OPC_RSW 10'h2d0
`define NTR_OPC_RSWD 10'h2f0
`define NTR_OPC_RSWI 10'h2e0
`define NTR_OPC_RST 10'h2b0
`define NTR_MSK_J 10'h3f0
// immediate field positions
`define NTR_X_HI 7
`define NTR_X_LO 4
`define NTR_Y_HI 3
`define NTR_Y_LO 0
`define NTR_Z_HI 1
`define NTR_J_HI 3
// values
`define NTR_ONE 4'h1
`define NTR_Y_TOP 4'hf
`define NTR_Y_BOT 4'h0
`define NTR_RST_NIB 4'h0
`define NTR_RST_BYTE 8'h00
`define NTR_RST_TRI 3'h0
`define NTR_RST_DUO 2'h0

`endif

// [rtl/ntr_pkg.sv]
package ntr_pkg;
    // skip sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_EXEC = 2'h1,
        ST_SKIP = 2'h2
    } ntr_skip_t;
    // decoded operation of this group
    typedef enum logic [4:0] {
        OP_NONE, OP_CPY_BA, OP_CPY_AB, OP_CPY_YA, OP_CPY_AY,
        OP_PACK_E, OP_UNPK_E, OP_CPY_AD, OP_CPY_DA, OP_CPY_ZA,
        OP_CPY_XA, OP_CPY_SA, OP_LXY, OP_LZ, OP_INC_Y, OP_DEC_Y,
        OP_RLD, OP_RSW, OP_RSWD, OP_RSWI, OP_RST
    } ntr_op_t;
endpackage

// [rtl/ntr_transfer_core.sv]
// Summary of operation
// - copy_b_to_acc: acc takes B
// - copy_acc_to_b: B takes acc
// - copy_y_to_acc: acc takes Y
// - copy_acc_to_y: Y takes acc
// - pack_ba_into_e: E gets B then acc
// - unpack_e_into_ba: B, acc from E halves
// - copy_acc_to_d: D takes acc bits 2..0
// - copy_d_to_acc: acc low bits take D
// - those D/SP copies zero acc bit 3
// - copy_z_to_acc: acc low bits take Z
// - copy_x_to_acc: acc takes X
// - copy_sp_to_acc: acc low bits take SP
// - load_xy_immediate loads X and Y
// - back-to-back load_xy: only first executes
// - load_z_immediate loads Z
// - inc_y_skip: Y+1, skip when zero
// - dec_y_skip: Y-1, skip when fifteen
// - ram_load_xor_x: acc from RAM, X^=j
// - ram_swap_xor_x: swap acc/RAM, X^=j
// - ram_swap_xor_dec_y: swap, X^=j, Y-1 skip
// - ram_swap_xor_inc_y: swap, X^=j, Y+1 skip
// - ram_store_xor_x: RAM from acc, X^=j
`timescale 1ns/1ps
`include "ntr_defines.svh"

module ntr_transfer_core
    import ntr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // instruction stream from the decoder
    input wire logic instrValid,
    input wire logic [9:0] instrWord,
    input wire logic [2:0] stackPtr,
    // data memory port at the data pointer
    input wire logic [3:0] ramRdData,
    output logic ramWrEn,
    output logic [3:0] ramWrData,
    // skip status
    output logic instrSkipped,
    output logic skipPending,
    // register file contents
    output logic [3:0] accOut,
    output logic [3:0] regB,
    output logic [3:0] regY,
    output logic [7:0] regE,
    output logic [2:0] regD,
    output logic [1:0] regZ,
    output logic [3:0] regX
);

    // reset synchroniser
    logic rstMeta_ff;
    logic rstSync_ff;
    // architectural registers
    logic [3:0] acc_ff;
    logic [3:0] b_ff;
    logic [3:0] y_ff;
    logic [7:0] e_ff;
    logic [2:0] d_ff;
    logic [1:0] z_ff;
    logic [3:0] x_ff;
    // skip sequencing
    ntr_skip_t skipState_ff;
    logic lxyRun_ff;
    // decode results
    ntr_op_t decOp;
    ntr_op_t exOp;
    logic discard;
    logic execNow;
    // immediate field and Y plus/minus one
    logic [3:0] immJ;
    logic [3:0] yInc;
    logic [3:0] yDec;

    // reset released through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    // instruction decode for this group
    always_comb begin
        decOp = OP_NONE;
        case (instrWord)
            `NTR_OPC_CPY_BA: decOp = OP_CPY_BA;
            `NTR_OPC_CPY_AB: decOp = OP_CPY_AB;
            `NTR_OPC_CPY_YA: decOp = OP_CPY_YA;
            `NTR_OPC_CPY_AY: decOp = OP_CPY_AY;
            `NTR_OPC_PACK_E: decOp = OP_PACK_E;
            `NTR_OPC_UNPK_E: decOp = OP_UNPK_E;
            `NTR_OPC_CPY_AD: decOp = OP_CPY_AD;
            `NTR_OPC_CPY_DA: decOp = OP_CPY_DA;
            `NTR_OPC_CPY_ZA: decOp = OP_CPY_ZA;
            `NTR_OPC_CPY_XA: decOp = OP_CPY_XA;
            `NTR_OPC_CPY_SA: decOp = OP_CPY_SA;
            `NTR_OPC_INC_Y: decOp = OP_INC_Y;
            `NTR_OPC_DEC_Y: decOp = OP_DEC_Y;
            default: begin
                // immediate-carrying codes
                if ((instrWord & `NTR_MSK_LXY) == `NTR_OPC_LXY) begin
                    decOp = OP_LXY;
                end else if ((instrWord & `NTR_MSK_LZ) == `NTR_OPC_LZ) begin
                    decOp = OP_LZ;
                end else if ((instrWord & `NTR_MSK_J) == `NTR_OPC_RLD) begin
                    decOp = OP_RLD;
                end else if ((instrWord & `NTR_MSK_J) == `NTR_OPC_RSW) begin
                    decOp = OP_RSW;
                end else if ((instrWord & `NTR_MSK_J) == `NTR_OPC_RSWD) begin
                    decOp = OP_RSWD;
                end else if ((instrWord & `NTR_MSK_J) == `NTR_OPC_RSWI) begin
                    decOp = OP_RSWI;
                end else if ((instrWord & `NTR_MSK_J) == `NTR_OPC_RST) begin
                    decOp = OP_RST;
                end
            end
        endcase
    end

    // discard when a skip is owed or a load_xy run continues
    assign discard = (skipState_ff == ST_SKIP)
        || ((decOp == OP_LXY) && lxyRun_ff);
    assign execNow = instrValid && !discard;
    assign exOp = execNow ? decOp : OP_NONE;
    assign immJ = instrWord[`NTR_J_HI:0];
    // four-bit arithmetic wraps by width
    assign yInc = y_ff + `NTR_ONE;
    assign yDec = y_ff - `NTR_ONE;
    // handshake-style outputs
    assign instrSkipped = instrValid && discard;
    assign skipPending = (skipState_ff == ST_SKIP);
    // memory write during the executing cycle
    assign ramWrEn = (exOp == OP_RSW) || (exOp == OP_RSWD)
        || (exOp == OP_RSWI) || (exOp == OP_RST);
    assign ramWrData = acc_ff;
    // registered data outputs
    assign accOut = acc_ff;
    assign regB = b_ff;
    assign regY = y_ff;
    assign regE = e_ff;
    assign regD = d_ff;
    assign regZ = z_ff;
    assign regX = x_ff;

    // accumulator
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            acc_ff <= `NTR_RST_NIB;
        end else begin
            case (exOp)
                OP_CPY_BA: acc_ff <= b_ff;
                OP_CPY_YA: acc_ff <= y_ff;
                OP_UNPK_E: acc_ff <= e_ff[3:0];
                OP_CPY_DA: acc_ff <= {1'b0, d_ff};
                OP_CPY_ZA: acc_ff <= {2'h0, z_ff};
                OP_CPY_XA: acc_ff <= x_ff;
                OP_CPY_SA: acc_ff <= {1'b0, stackPtr};
                // load or swap with memory
                OP_RLD, OP_RSW, OP_RSWD, OP_RSWI: acc_ff <= ramRdData;
                default: acc_ff <= acc_ff;
            endcase
        end
    end

    // register B
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            b_ff <= `NTR_RST_NIB;
        end else if (exOp == OP_CPY_AB) begin
            b_ff <= acc_ff;
        end else if (exOp == OP_UNPK_E) begin
            b_ff <= e_ff[7:4];
        end
    end

    // register Y, with wrap
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            y_ff <= `NTR_RST_NIB;
        end else begin
            case (exOp)
                OP_CPY_AY: y_ff <= acc_ff;
                OP_LXY: y_ff <= instrWord[`NTR_Y_HI:`NTR_Y_LO];
                OP_INC_Y, OP_RSWI: y_ff <= yInc;
                OP_DEC_Y, OP_RSWD: y_ff <= yDec;
                default: y_ff <= y_ff;
            endcase
        end
    end

    // register E
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            e_ff <= `NTR_RST_BYTE;
        end else if (exOp == OP_PACK_E) begin
            e_ff <= {b_ff, acc_ff};
        end
    end
    // register D
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            d_ff <= `NTR_RST_TRI;
        end else if (exOp == OP_CPY_AD) begin
            d_ff <= acc_ff[2:0];
        end
    end
    // register Z
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            z_ff <= `NTR_RST_DUO;
        end else if (exOp == OP_LZ) begin
            z_ff <= instrWord[`NTR_Z_HI:0];
        end
    end

    // register X
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            x_ff <= `NTR_RST_NIB;
        end else begin
            case (exOp)
                OP_LXY: x_ff <= instrWord[`NTR_X_HI:`NTR_X_LO];
                OP_RLD, OP_RSW, OP_RSWD, OP_RSWI, OP_RST: begin
                    // address toggle after the memory access
                    x_ff <= x_ff ^ immJ;
                end
                default: x_ff <= x_ff;
            endcase
        end
    end

    // skip sequencer: one discarded instruction after a wrap
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            skipState_ff <= ST_EXEC;
        end else begin
            case (skipState_ff)
                ST_EXEC: begin
                    // wrap of Y arms the skip
                    if (((exOp == OP_INC_Y) || (exOp == OP_RSWI))
                        && (yInc == `NTR_Y_BOT)) begin
                        skipState_ff <= ST_SKIP;
                    end else if (((exOp == OP_DEC_Y) || (exOp == OP_RSWD))
                        && (yDec == `NTR_Y_TOP)) begin
                        skipState_ff <= ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    // the next instruction is consumed unexecuted
                    if (instrValid) begin
                        skipState_ff <= ST_EXEC;
                    end
                end
                default: skipState_ff <= ST_EXEC;
            endcase
        end
    end

    // tracks a run of load_xy codes, skipped or not
    always_ff @(posedge core_clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            lxyRun_ff <= 1'b0;
        end else if (instrValid) begin
            lxyRun_ff <= (decOp == OP_LXY);
        end
    end
    // checks on the executed effect
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstSync_ff);
    copy_b_acc_a: assert property ((exOp == OP_CPY_BA) |=>
        (acc_ff == $past(b_ff)) && $stable(b_ff) && !skipPending) else $error("acc not from B");
    copy_acc_b_a: assert property ((exOp == OP_CPY_AB) |=>
        (b_ff == $past(acc_ff)) && $stable(acc_ff)) else $error("B not loaded from acc");
    copy_y_acc_a: assert property ((exOp == OP_CPY_YA) |=>
        (acc_ff == $past(y_ff)) && $stable(y_ff)) else $error("acc not loaded from Y");
    copy_acc_y_a: assert property ((exOp == OP_CPY_AY) |=>
        (y_ff == $past(acc_ff)) && $stable(acc_ff)) else $error("Y not loaded from acc");
    pack_e_a: assert property ((exOp == OP_PACK_E) |=>
        (e_ff == {$past(b_ff), $past(acc_ff)})) else $error("E pack wrong");
    unpack_e_a: assert property ((exOp == OP_UNPK_E) |=>
        ({b_ff, acc_ff} == $past(e_ff))) else $error("E unpack wrong");
    copy_acc_d_a: assert property ((exOp == OP_CPY_AD) |=>
        (d_ff == $past(acc_ff[2:0]))) else $error("D not loaded from acc");
    copy_d_acc_a: assert property ((exOp == OP_CPY_DA) |=>
        (acc_ff == {1'b0, $past(d_ff)})) else $error("acc not loaded from D");
    acc_top_zero_a: assert property (((exOp == OP_CPY_DA) || (exOp == OP_CPY_SA)) |=>
        !acc_ff[3]) else $error("acc bit 3 not cleared");
    copy_z_acc_a: assert property ((exOp == OP_CPY_ZA) |=>
        (acc_ff == {2'h0, $past(z_ff)})) else $error("acc not loaded from Z");
    copy_x_acc_a: assert property ((exOp == OP_CPY_XA) |=>
        (acc_ff == $past(x_ff)) && !skipPending) else $error("acc not loaded from X");
    copy_sp_acc_a: assert property ((exOp == OP_CPY_SA) |=>
        (acc_ff[2:0] == $past(stackPtr))) else $error("acc not loaded from SP");
    load_xy_a: assert property ((exOp == OP_LXY) |=>
        ({x_ff, y_ff} == $past(instrWord[7:0]))) else $error("X/Y immediate not loaded");
    lxy_run_a: assert property ((instrValid && (decOp == OP_LXY)) ##1
        (instrValid && (decOp == OP_LXY)) |-> instrSkipped && (exOp == OP_NONE))
        else $error("second load_xy executed");
    load_z_a: assert property ((exOp == OP_LZ) |=>
        (z_ff == $past(instrWord[1:0]))) else $error("Z immediate not loaded");
    inc_y_a: assert property ((exOp == OP_INC_Y) |=>
        (y_ff == $past(y_ff) + 4'h1) && (skipPending == (y_ff == 4'h0))) else $error("bad inc Y");
    dec_y_a: assert property ((exOp == OP_DEC_Y) |=>
        (y_ff == $past(y_ff) - 4'h1) && (skipPending == (y_ff == 4'hf))) else $error("bad dec Y");
    ram_load_a: assert property ((exOp == OP_RLD) |-> !ramWrEn ##1
        (acc_ff == $past(ramRdData)) && (x_ff == ($past(x_ff) ^ $past(immJ))))
        else $error("memory load wrong");
    ram_swap_a: assert property ((exOp == OP_RSW) |-> ramWrEn &&
        (ramWrData == acc_ff) ##1 (acc_ff == $past(ramRdData)) && !skipPending &&
        (x_ff == ($past(x_ff) ^ $past(immJ)))) else $error("memory swap wrong");
    swap_dec_a: assert property ((exOp == OP_RSWD) |-> ramWrEn ##1
        (y_ff == $past(y_ff) - 4'h1) && (skipPending == (y_ff == 4'hf))) else $error("swap dec");
    swap_inc_a: assert property ((exOp == OP_RSWI) |-> ramWrEn ##1
        (y_ff == $past(y_ff) + 4'h1) && (skipPending == (y_ff == 4'h0))) else $error("swap inc");
    ram_store_a: assert property ((exOp == OP_RST) |-> ramWrEn &&
        (ramWrData == acc_ff) ##1 $stable(acc_ff) && (x_ff == ($past(x_ff) ^ $past(immJ))))
        else $error("memory store wrong");
    skip_once_a: assert property ((skipPending && instrValid) |->
        instrSkipped ##1 !skipPending) else $error("skip not taken once");
    y_wrap_a: assert property (((exOp == OP_INC_Y) && (y_ff == 4'hf)) |=>
        (y_ff == 4'h0)) else $error("Y did not wrap to zero");
    // main scenarios
    wrap_skip_c: cover property ((exOp == OP_INC_Y) ##1 instrSkipped);
    lxy_run_c: cover property ((exOp == OP_LXY) ##1 instrSkipped);
    swap_dec_c: cover property ((exOp == OP_RSWD) ##1 skipPending);
    pack_unpk_c: cover property ((exOp == OP_PACK_E) ##[1:4] (exOp == OP_UNPK_E));

endmodule

// [tb/tb_nibble_transfer_ram_addr_ops.sv]
`timescale 1ns/1ps
`include "ntr_defines.svh"

module tb_nibble_transfer_ram_addr_ops;
    // stimulus side of the core
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instrValid = 1'b0;
    logic [9:0] instrWord = 10'h000;
    logic [2:0] stackPtr = 3'h0;
    logic [3:0] ramRdData;
    // observed outputs
    logic ramWrEn;
    logic instrSkipped;
    logic skipPending;
    logic [3:0] ramWrData;
    logic [3:0] accOut;
    logic [3:0] regB;
    logic [3:0] regY;
    logic [3:0] regX;
    logic [7:0] regE;
    logic [2:0] regD;
    logic [1:0] regZ;
    // bookkeeping
    int fail_count = 0;
    int num_checks = 0;
    // data memory behind the pointer
    logic [3:0] mem [1024];
    // expected register file
    logic [3:0] expAcc = 4'h0;
    logic [3:0] expB = 4'h0;
    logic [3:0] expY = 4'h0;
    logic [3:0] expX = 4'h0;
    logic [7:0] expE = 8'h00;
    logic [2:0] expD = 3'h0;
    logic [1:0] expZ = 2'h0;
    logic expSkip = 1'b0;
    logic lastLxy = 1'b0;

    // free-running core clock, 4 ns
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    ntr_transfer_core i_ntr_transfer_core (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .instrValid(instrValid),
        .instrWord(instrWord),
        .stackPtr(stackPtr),
        .ramRdData(ramRdData),
        .ramWrEn(ramWrEn),
        .ramWrData(ramWrData),
        .instrSkipped(instrSkipped),
        .skipPending(skipPending),
        .accOut(accOut),
        .regB(regB),
        .regY(regY),
        .regE(regE),
        .regD(regD),
        .regZ(regZ),
        .regX(regX)
    );

    // combinational read, write at the executing edge
    assign ramRdData = mem[{regZ, regX, regY}];
    always @(posedge core_clk) begin
        if (ramWrEn === 1'b1) begin
            mem[{regZ, regX, regY}] <= ramWrData;
        end
    end

    // one comparison, reported at once
    task chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    // present one instruction at the falling edge, model it, judge the result
    task automatic issue(input logic [9:0] w, input logic [2:0] ptr = 3'h6);
        logic skip;
        logic wr;
        logic [3:0] m;
        logic [3:0] j;
        m = mem[{expZ, expX, expY}];
        j = w[3:0];
        skip = expSkip | (lastLxy & (w[9:8] == 2'h3));
        wr = !skip & (w[9:4] inside {6'h2d, 6'h2f, 6'h2e, 6'h2b});
        instrValid = 1'b1;
        instrWord = w;
        stackPtr = ptr;
        #1;
        chk(instrSkipped === skip, "discard flag");
        chk(ramWrEn === wr, "memory write enable");
        if (wr) begin
            chk(ramWrData === expAcc, "memory write data");
        end
        expSkip = 1'b0;
        lastLxy = (w[9:8] == 2'h3);
        if (!skip) begin
            casez (w)
                10'h01e: expAcc = expB;
                10'h00e: expB = expAcc;
                10'h01f: expAcc = expY;
                10'h00c: expY = expAcc;
                10'h01a: expE = {expB, expAcc};
                10'h02a: {expB, expAcc} = expE;
                10'h029: expD = expAcc[2:0];
                10'h051: expAcc = {1'b0, expD};
                10'h053: expAcc = {2'h0, expZ};
                10'h052: expAcc = expX;
                10'h050: expAcc = {1'b0, ptr};
                10'h013: begin
                    expY = expY + 4'h1;
                    expSkip = (expY == 4'h0);
                end
                10'h017: begin
                    expY = expY - 4'h1;
                    expSkip = (expY == 4'hf);
                end
                10'b11????????: begin
                    expX = w[7:4];
                    expY = w[3:0];
                end
                10'b00010010??: expZ = w[1:0];
                10'b10110?????: begin
                    expAcc = m;
                    expX = expX ^ j;
                end
                10'b101111????: begin
                    expAcc = m;
                    expX = expX ^ j;
                    expY = expY - 4'h1;
                    expSkip = (expY == 4'hf);
                end
                10'b101110????: begin
                    expAcc = m;
                    expX = expX ^ j;
                    expY = expY + 4'h1;
                    expSkip = (expY == 4'h0);
                end
                10'b101011????: expX = expX ^ j;
                // outside this group: nothing changes
                default: ;
            endcase
        end
        @(negedge core_clk);
        chk(accOut === expAcc && regB === expB && regY === expY && regX === expX, "a b y x");
        chk(regE === expE && regD === expD && regZ === expZ, "e d z");
        chk(skipPending === expSkip, "pending skip");
    endtask

    // one empty cycle
    task idle();
        instrValid = 1'b0;
        @(negedge core_clk);
    endtask

    // register to register copies, including the zero-extended ones
    task t_copies();
        issue(`NTR_OPC_LXY | 10'h0a3);
        issue(`NTR_OPC_RLD | 10'h000);
        issue(`NTR_OPC_CPY_AB);
        issue(`NTR_OPC_RLD | 10'h00f);
        issue(`NTR_OPC_CPY_BA);
        issue(`NTR_OPC_CPY_AY);
        issue(`NTR_OPC_RLD | 10'h001);
        issue(`NTR_OPC_CPY_YA);
        issue(`NTR_OPC_PACK_E);
        issue(`NTR_OPC_RLD | 10'h002);
        issue(`NTR_OPC_UNPK_E);
        issue(`NTR_OPC_CPY_XA);
        issue(`NTR_OPC_CPY_AD);
        issue(`NTR_OPC_LZ | 10'h003);
        issue(`NTR_OPC_CPY_XA);
        issue(`NTR_OPC_CPY_DA);
        issue(`NTR_OPC_CPY_XA);
        issue(`NTR_OPC_CPY_ZA);
        issue(`NTR_OPC_CPY_XA);
        issue(`NTR_OPC_CPY_SA, 3'h7);
        issue(`NTR_OPC_CPY_SA, 3'h2);
        $display("copies done");
    endtask

    // runs of address loads, with a gap and with a breaker
    task t_lxy();
        issue(`NTR_OPC_LXY | 10'h012);
        issue(`NTR_OPC_LXY | 10'h034);
        issue(`NTR_OPC_LXY | 10'h056);
        idle();
        issue(`NTR_OPC_LXY | 10'h078);
        issue(10'h07a);
        issue(`NTR_OPC_LXY | 10'h09b);
        for (int z = 0; z < 4; z++) begin
            issue(`NTR_OPC_LZ | 10'(z));
        end
        $display("address loads done");
    endtask

    // increment and decrement with wrap and skip
    task t_inc_dec();
        issue(`NTR_OPC_LXY | 10'h00f);
        issue(`NTR_OPC_INC_Y);
        issue(`NTR_OPC_CPY_AB);
        issue(`NTR_OPC_DEC_Y);
        issue(`NTR_OPC_LXY | 10'h000);
        issue(`NTR_OPC_LXY | 10'h001);
        issue(`NTR_OPC_DEC_Y);
        issue(`NTR_OPC_INC_Y);
        issue(`NTR_OPC_CPY_YA);
        $display("increment and decrement done");
    endtask

    // memory load, swaps and store, with skip on wrap
    task t_ram();
        issue(`NTR_OPC_LXY | 10'h03e);
        issue(`NTR_OPC_RSW | 10'h005);
        issue(`NTR_OPC_RSWI | 10'h009);
        issue(`NTR_OPC_RSWI | 10'h000);
        issue(`NTR_OPC_CPY_BA);
        issue(`NTR_OPC_RSWD | 10'h006);
        issue(`NTR_OPC_RST | 10'h000);
        issue(`NTR_OPC_RST | 10'h00c);
        issue(`NTR_OPC_RLD | 10'h003);
        issue(`NTR_OPC_RSWD | 10'h001);
        issue(`NTR_OPC_RSW | 10'h000);
        idle();
        $display("memory transfers done");
    endtask

    // asynchronous clear in mid-run drops a pending skip and all registers
    task t_reset();
        issue(`NTR_OPC_LXY | 10'h05f);
        issue(`NTR_OPC_INC_Y);
        instrValid = 1'b0;
        rst_n = 1'b0;
        #1;
        chk(accOut === 4'h0 && regB === 4'h0 && regY === 4'h0 && regX === 4'h0, "clear a b y x");
        chk(regE === 8'h00 && regD === 3'h0 && regZ === 2'h0 && skipPending === 1'b0, "clear e d z");
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        {expAcc, expB, expY, expX, expE, expD, expZ} = '0;
        expSkip = 1'b0;
        lastLxy = 1'b0;
        issue(`NTR_OPC_LXY | 10'h021);
        issue(`NTR_OPC_INC_Y);
        $display("mid-run reset done");
    endtask

    // verdict and end of run
    task finish_test();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog at 5000 cycles, well beyond the fewer than one hundred cycles needed
    initial begin
        #(5000 * 4);
        fail_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        finish_test();
    end

    // main sequence
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 4'(i * 7 + 3);
        end
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(accOut === 4'h0 && regE === 8'h00 && skipPending === 1'b0, "reset values");
        t_copies();
        t_lxy();
        t_inc_dec();
        t_ram();
        t_reset();
        finish_test();
    end
endmodule
